// >>> usb_host_flags_consts.svh
// Offsets, bit positions and timing constants of the host interrupt flags
`ifndef USB_HOST_FLAGS_CONSTS_SVH
`define USB_HOST_FLAGS_CONSTS_SVH
`define FLAGS_ADDR 4'h0
`define ERRMASK_ADDR 4'h4
`define ERRSTAT_ADDR 4'h8
`define BIT_STALL 7
`define BIT_ATTACH 6
`define BIT_RESUME 5
`define BIT_IDLE 4
`define BIT_TOKEN 3
`define BIT_FRAME 2
`define BIT_ERROR 1
`define BIT_DETACH 0
`define FLAGS_RESET 8'h00
`define CLK_MHZ 125
`define ATTACH_NS 2500
`define RESUME_NS 2500
`define IDLE_US 3000
`define ATTACH_CYC ((`ATTACH_NS * `CLK_MHZ + 999) / 1000)
`define RESUME_CYC ((`RESUME_NS * `CLK_MHZ + 999) / 1000)
`define IDLE_CYC (`IDLE_US * `CLK_MHZ)
`endif

// >>> usb_host_flags_pkg.sv
// Types shared by the host interrupt flag logic
package usb_host_flags_pkg;
	typedef enum logic [1:0] {LINE_SE0, LINE_J, LINE_K, LINE_SE1} line_type;
	typedef logic [15:0] word_type;
endpackage

// >>> line_timer.sv
// Counts how long a condition has held and pulses once when it reaches a limit
`timescale 1ns/10ps
module line_timer #(
	parameter int WIDTH = 20,
	parameter logic [WIDTH-1:0] LIMIT = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Condition and result
	input wire logic hold,
	output logic reached
);
	logic [WIDTH-1:0] count_q;
	logic done_q;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			count_q <= '0;
		else if (clkEn)
		begin
			if (!hold)
				count_q <= '0;
			else if (count_q != LIMIT)
				count_q <= count_q + 1'b1;
		end
	end

	// One pulse per stretch; reset only when the condition drops
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			done_q <= 1'b0;
		else if (clkEn)
			done_q <= hold && (count_q == LIMIT);
	end

	assign reached = hold && (count_q == LIMIT) && !done_q;
endmodule // line_timer

// >>> usb_host_interrupt_status.sv
// Host-mode USB interrupt status flags with register port
//
// Summary of operation
// - Bits 15:8 read zero, writes ignored
// - Attach: non-SE0, no activity for 2.5 us
// - Resume: K-state held 2.5 us
// - Idle: bus idle 3 ms or longer
// - Token done sets flag, status shown
// - Frame flag at start-of-frame threshold
// - Stall flag on STALL handshake
// - Error summary read-only, enabled errors only
// - Detach flag; not again until cleared
`timescale 1ns/10ps
`include "usb_host_flags_consts.svh"
module usb_host_interrupt_status #(
	parameter int IDLE_CYCLES = `IDLE_CYC,
	parameter int ERR_BITS = 8,
	parameter int TOKEN_BITS = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Bus line state from the transceiver (asynchronous)
	input wire logic dPlus,
	input wire logic dMinus,
	input wire logic lowSpeed,
	// Engine events (same clock)
	input wire logic busActivity,
	input wire logic detachSeen,
	input wire logic tokenDone,
	input wire logic [TOKEN_BITS-1:0] tokenInfo,
	input wire logic frameThreshold,
	input wire logic stallSeen,
	input wire logic [ERR_BITS-1:0] errorEvents,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output usb_host_flags_pkg::word_type rdData,
	// Status
	output logic [TOKEN_BITS-1:0] tokenStatus,
	output logic [7:0] flags
);
	import usb_host_flags_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] lineMeta_q;
	logic [1:0] lineSync_q;
	line_type line;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			lineMeta_q <= 2'b00;
			lineSync_q <= 2'b00;
		end
		else if (clkEn)
		begin
			lineMeta_q <= {dPlus, dMinus};
			lineSync_q <= lineMeta_q;
		end
	end

	always_comb
	begin
		case (lineSync_q)
			2'b00: line = LINE_SE0;
			2'b10: line = lowSpeed ? LINE_K : LINE_J;
			2'b01: line = lowSpeed ? LINE_J : LINE_K;
			default: line = LINE_SE1;
		endcase
	end

	// ------------------------------------------------------------
	// Bus state detectors
	// ------------------------------------------------------------
	logic attachHit;
	logic resumeHit;
	logic idleHit;
	logic idleState;

	// Idle is J with no engine activity
	assign idleState = (line == LINE_J) && !busActivity;

	line_timer #(
		.WIDTH(16),
		.LIMIT(16'(`ATTACH_CYC))
	) attachTimer (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.hold((line != LINE_SE0) && !busActivity),
		.reached(attachHit)
	);

	line_timer #(
		.WIDTH(16),
		.LIMIT(16'(`RESUME_CYC))
	) resumeTimer (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.hold(line == LINE_K),
		.reached(resumeHit)
	);

	line_timer #(
		.WIDTH(32),
		.LIMIT(32'(IDLE_CYCLES))
	) idleTimer (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.hold(idleState),
		.reached(idleHit)
	);

	// ------------------------------------------------------------
	// Error summary
	// ------------------------------------------------------------
	logic [ERR_BITS-1:0] errMask_q;
	logic [ERR_BITS-1:0] errStat_q;
	logic wrFlags;
	logic wrMask;
	logic wrErr;

	assign wrFlags = wrStb && (addr == `FLAGS_ADDR);
	assign wrMask = wrStb && (addr == `ERRMASK_ADDR);
	assign wrErr = wrStb && (addr == `ERRSTAT_ADDR);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			errMask_q <= '0;
		else if (clkEn && wrMask)
			errMask_q <= wrData[ERR_BITS-1:0];
	end

	// Error causes: set wins over write-one-clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			errStat_q <= '0;
		else if (clkEn)
			errStat_q <= (errStat_q & ~(wrErr ? wrData[ERR_BITS-1:0]
				: {ERR_BITS{1'b0}})) | errorEvents;
	end

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	logic [7:0] flags_q;
	logic [7:0] setEv;
	logic [7:0] clrBits;
	logic detachArm_q;

	// Detach can only fire again once software clears it
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			detachArm_q <= 1'b1;
		else if (clkEn)
		begin
			if (detachSeen && detachArm_q)
				detachArm_q <= 1'b0;
			else if (wrFlags && wrData[`BIT_DETACH])
				detachArm_q <= 1'b1;
		end
	end

	always_comb
	begin
		setEv = 8'h00;
		setEv[`BIT_STALL] = stallSeen;
		setEv[`BIT_ATTACH] = attachHit;
		setEv[`BIT_RESUME] = resumeHit;
		setEv[`BIT_IDLE] = idleHit;
		setEv[`BIT_TOKEN] = tokenDone;
		setEv[`BIT_FRAME] = frameThreshold;
		setEv[`BIT_DETACH] = detachSeen && detachArm_q;
	end

	// Upper byte of write data never reaches the flags
	assign clrBits = wrFlags ? wrData[7:0] : 8'h00;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			flags_q <= `FLAGS_RESET;
		else if (clkEn)
			flags_q <= (flags_q & ~clrBits) | setEv;
	end

	// Summary is live, never stored or cleared directly
	always_comb
	begin
		flags = flags_q;
		flags[`BIT_ERROR] = |(errStat_q & errMask_q);
	end

	// ------------------------------------------------------------
	// Token status
	// ------------------------------------------------------------
	// Captured only while the previous token is acknowledged
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			tokenStatus <= '0;
		else if (clkEn && tokenDone && !flags_q[`BIT_TOKEN])
			tokenStatus <= tokenInfo;
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rdData <= 16'h0000;
		else if (clkEn)
		begin
			if (!rdStb)
				rdData <= 16'h0000;
			else
				case (addr)
					`FLAGS_ADDR: rdData <= {8'h00, flags};
					`ERRMASK_ADDR: rdData <= 16'(errMask_q);
					`ERRSTAT_ADDR: rdData <= 16'(errStat_q);
					default: rdData <= 16'h0000;
				endcase
		end
	end
endmodule // usb_host_interrupt_status

// >>> usb_host_flags_checker_assertions.sv
// Port-level assertions for the host interrupt flag block
`timescale 1ns/10ps
module usb_host_flags_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Events, register port, status
	input wire logic tokenDone,
	input wire logic frameThreshold,
	input wire logic stallSeen,
	input wire logic [3:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input usb_host_flags_pkg::word_type rdData,
	input wire logic [7:0] flags
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence clr_stall_s;
		clkEn && wrStb && addr == 4'h0 && wrData[7];
	endsequence
	upper_zero_a: assert property (rdData[15:8] == 8'h00)
		else $error("upper byte set");
	// A frozen cycle keeps the last read word, so only running cycles count
	quiet_read_a: assert property (clkEn && !rdStb
		|=> rdData == 16'h0000) else $error("data without read");
	stall_set_a: assert property (clkEn && stallSeen
		|=> flags[7]) else $error("stall flag missed");
	token_set_a: assert property (clkEn && tokenDone
		|=> flags[3]) else $error("token flag missed");
	frame_set_a: assert property (clkEn && frameThreshold
		|=> flags[2]) else $error("frame flag missed");
	stall_clear_a: assert property (clr_stall_s ##0 !stallSeen
		|=> !flags[7]) else $error("stall flag not cleared");
	stall_keep_a: assert property (flags[7]
		&& !(wrStb && wrData[7]) |=> flags[7])
		else $error("stall flag lost");
	read_flags_a: assert property (clkEn && rdStb && addr == 4'h0
		|=> rdData[7:0] == $past(flags)) else $error("read mismatch");
	freeze_hold_a: assert property (!clkEn
		|=> $stable(flags) && $stable(rdData))
		else $error("state moved while frozen");
endmodule // usb_host_flags_checker

bind usb_host_interrupt_status usb_host_flags_checker chk (.clk, .rst_b,
	.clkEn, .tokenDone, .frameThreshold, .stallSeen, .addr, .wrData, .wrStb,
	.rdStb, .rdData, .flags);

// >>> usb_peer_model.sv
// Attached peripheral: drives the bus lines to a requested state
`timescale 1ns/10ps
module usb_peer_model (
	// Requested state
	input wire logic lowSpeed,
	input usb_host_flags_pkg::line_type lineState,
	// Bus lines
	output logic dPlus,
	output logic dMinus
);
	import usb_host_flags_pkg::*;
	// Low speed swaps which line carries J and K
	assign dPlus = (lineState == LINE_J) ? !lowSpeed :
		(lineState == LINE_K) ? lowSpeed : lineState == LINE_SE1;
	assign dMinus = (lineState == LINE_J) ? lowSpeed :
		(lineState == LINE_K) ? !lowSpeed : lineState == LINE_SE1;
endmodule // usb_peer_model

// >>> test_usb_host_interrupt_status.sv
// Self-checking bench for the host interrupt flag block
`timescale 1ns/10ps
module test_usb_host_interrupt_status;
	import usb_host_flags_pkg::*;
	logic clk = 0, rst_b = 0, dPlus, dMinus, lowSpeed = 0, busActivity = 1;
	logic detachSeen = 0, tokenDone = 0, frameThreshold = 0, stallSeen = 0;
	logic wrStb = 0, rdStb = 0, clkEn = 1;
	logic [7:0] errorEvents = 8'h00, flags, tokenStatus, tokenInfo = 8'hA5;
	logic [3:0] addr = 4'h0;
	logic [15:0] wrData = 16'h0000;
	word_type rdData;
	line_type lineState = LINE_SE0;
	int n_fail = 0, n_tests = 0, cycles = 0;
	always #4 clk = !clk;
	usb_peer_model peer (.lowSpeed, .lineState, .dPlus, .dMinus);
	usb_host_interrupt_status #(.IDLE_CYCLES(50)) dut (.clk, .rst_b,
		.clkEn, .dPlus, .dMinus, .lowSpeed, .busActivity, .detachSeen,
		.tokenDone, .tokenInfo, .frameThreshold, .stallSeen,
		.errorEvents, .addr, .wrData, .wrStb, .rdStb, .rdData, .tokenStatus,
		.flags);
	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One register access; a read compares against d
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wrStb <= w;
		rdStb <= !w;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		wrStb <= 1'b0;
		rdStb <= 1'b0;
		if (!w)
			#1 chk(rdData, d);
	endtask
	task automatic ev(input logic [3:0] m, input logic [7:0] e);
		@(posedge clk);
		{stallSeen, tokenDone, frameThreshold, detachSeen} <= m;
		errorEvents <= e;
		@(posedge clk);
		{stallSeen, tokenDone, frameThreshold, detachSeen} <= 4'h0;
		errorEvents <= 8'h00;
	endtask
	// Line state held long enough for every detector to fire
	task automatic hold(input line_type s, input logic act, input logic [15:0] e);
		@(posedge clk);
		lineState <= s;
		busActivity <= act;
		repeat (400) @(posedge clk);
		acc(0, 4'h0, e);
	endtask
	task automatic engine_events();
		ev(4'hF, 8'h00);
		acc(0, 4'h0, 16'h008D);
		chk({8'h00, tokenStatus}, 16'h00A5);
		// Second token while the flag is still set must not overwrite status
		tokenInfo <= 8'h3C;
		ev(4'h4, 8'h00);
		acc(1, 4'h0, 16'hFF84);
		acc(0, 4'h0, 16'h0009);
		chk({8'h00, tokenStatus}, 16'h00A5);
		acc(1, 4'h0, 16'h00FF);
		acc(0, 4'h0, 16'h0000);
		ev(4'h4, 8'h00);
		acc(0, 4'h0, 16'h0008);
		chk({8'h00, tokenStatus}, 16'h003C);
		acc(1, 4'h0, 16'h00FF);
	endtask
	task automatic line_events();
		hold(LINE_J, 1, 16'h0000);
		hold(LINE_J, 0, 16'h0050);
		acc(1, 4'h0, 16'h00FF);
		hold(LINE_K, 0, 16'h0020);
		acc(1, 4'h0, 16'h00FF);
		lowSpeed <= 1'b1;
		hold(LINE_SE0, 0, 16'h0000);
		hold(LINE_K, 0, 16'h0060);
		acc(1, 4'h0, 16'h00FF);
	endtask
	task automatic error_events();
		acc(1, 4'h4, 16'h0001);
		ev(4'h0, 8'h02);
		acc(0, 4'h0, 16'h0000);
		ev(4'h0, 8'h01);
		acc(0, 4'h0, 16'h0002);
		acc(0, 4'h8, 16'h0003);
		acc(1, 4'h0, 16'h0002);
		acc(0, 4'h0, 16'h0002);
		acc(1, 4'h8, 16'h00FF);
		acc(0, 4'h0, 16'h0000);
		acc(0, 4'hC, 16'h0000);
	endtask
	// Frozen enable drops events and writes; then a reset in mid-run
	task automatic freeze_events();
		@(posedge clk);
		clkEn <= 1'b0;
		ev(4'h8, 8'h00);
		acc(1, 4'h4, 16'h00FF);
		@(posedge clk);
		clkEn <= 1'b1;
		acc(0, 4'h0, 16'h0000);
		acc(0, 4'h4, 16'h0001);
		ev(4'h8, 8'h00);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		acc(0, 4'h0, 16'h0000);
		acc(0, 4'h4, 16'h0000);
	endtask
	// Hang guard, well above the roughly 2100 cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		acc(0, 4'h0, 16'h0000);
		engine_events();
		line_events();
		error_events();
		freeze_events();
		give_verdict();
	end
endmodule // test_usb_host_interrupt_status
